//--- cco_map.svh
/*
  Opcode field encodings and condition-code bit positions
  for the clear and compare decoder. Included by the package and the decoder.
*/
`ifndef CCO_MAP_SVH
`define CCO_MAP_SVH

`define CCO_CLR_PREFIX 8'h42
`define CCO_CMP_PREFIX 4'hb
`define CCO_SZ_BYTE 2'h0
`define CCO_SZ_WORD 2'h1
`define CCO_SZ_LONG 2'h2
`define CCO_OPM_CMP_B 3'h0
`define CCO_OPM_CMP_W 3'h1
`define CCO_OPM_CMP_L 3'h2
`define CCO_OPM_COMPARE_ADDRESS_REG_OP_W 3'h3
`define CCO_OPM_COMPARE_ADDRESS_REG_OP_L 3'h7
`define CCO_EA_DREG 3'h0
`define CCO_EA_AREG 3'h1
`define CCO_EA_IND 3'h2
`define CCO_EA_POSTINC 3'h3
`define CCO_EA_PREDEC 3'h4
`define CCO_EA_DISP 3'h5
`define CCO_EA_INDEX 3'h6
`define CCO_EA_EXT 3'h7
`define CCO_EXT_ABS_W 3'h0
`define CCO_EXT_ABS_L 3'h1
`define CCO_EXT_PC_DISP 3'h2
`define CCO_EXT_PC_INDEX 3'h3
`define CCO_EXT_IMM 3'h4
`define CCO_CC_X 4
`define CCO_CC_N 3
`define CCO_CC_Z 2
`define CCO_CC_V 1
`define CCO_CC_C 0

`endif

//--- cco_pkg.sv
/*
  Types for the clear and compare decoder.
  Assumes cco_map.svh is on the include path.
*/
`include "cco_map.svh"

package cco_pkg;
  typedef enum logic [1:0] {
    CCO_SIZE_BYTE = `CCO_SZ_BYTE,
    CCO_SIZE_WORD = `CCO_SZ_WORD,
    CCO_SIZE_LONG = `CCO_SZ_LONG
  } cco_size_e;

  typedef enum logic [2:0] {
    CCO_IDLE = 3'h1,
    CCO_BUSY = 3'h2,
    CCO_DONE = 3'h4
  } cco_state_e;

  typedef logic [4:0] cco_ccr_t;
endpackage

//--- cco_decoder.sv
/*
  Decoder and datapath for the clear, data-register compare and
  address-register compare operations. Assumes the core supplies the opcode
  with a one-cycle start pulse, the source operand already fetched (word
  and byte data in the low bits), the destination register values and the
  current condition codes, all on mclk.
  Starts must come at least three cycles apart. A start that arrives while
  an operation is in flight is ignored without notice. Results hold until
  the next accepted start.
*/
`timescale 1ns/100ps
`include "cco_map.svh"

// How it works
// RULE1 - clear writes zero, sets Z, clears NVC
// RULE2 - clear size 00 byte, 01 word, 10 long
// RULE3 - clear destination only data-alterable modes
// RULE4 - data compare subtracts source, register unchanged
// RULE5 - data compare flags N Z V C, X kept
// RULE6 - data compare register field, opmode 000/001/010
// RULE7 - data compare any mode, address direct not byte
// RULE8 - address compare, word source sign-extended
// RULE9 - address compare flags N Z V C, X kept
// RULE10 - address compare opmode 011 word, 111 long
// RULE11 - address compare accepts every addressing mode
// RULE12 - clear opcode 01000010 in bits 15..8
// RULE13 - compare opcodes 1011 in bits 15..12
module cco_decoder #(
  parameter int DATA_W = 32
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] opcode,
  input wire logic [DATA_W-1:0] src_operand,
  input wire logic [DATA_W-1:0] data_register,
  input wire logic [DATA_W-1:0] address_register,
  input wire cco_pkg::cco_ccr_t ccr_in,
  output logic done,
  output logic illegal,
  output logic [2:0] reg_sel,
  output logic dst_write,
  output logic [DATA_W-1:0] dst_data,
  output logic [3:0] dst_byte_en,
  output logic [5:0] dst_ea,
  output cco_pkg::cco_ccr_t ccr_out,
  output logic ccr_write
);
  import cco_pkg::*;

  // ********************************
  // Helpers
  // ********************************
  // Byte enables for a size
  function automatic logic [3:0] size_mask(input logic [1:0] sz);
    unique case (sz)
      `CCO_SZ_BYTE: size_mask = 4'h1;
      `CCO_SZ_WORD: size_mask = 4'h3;
      default: size_mask = 4'hf;
    endcase
  endfunction

  // Signed overflow from operand and result signs
  function automatic logic sub_overflow(input logic dm, input logic sm, input logic rm);
    sub_overflow = (dm != sm) && (rm != dm);
  endfunction

  // Subtract and form N Z V C at the given size
  function automatic logic [3:0] sub_flags(input logic [31:0] d, input logic [31:0] s,
                                           input logic [1:0] sz);
    logic [32:0] diff;
    logic n;
    logic z;
    logic v;
    logic c;
    logic dm;
    logic sm;
    diff = {1'b0, d} - {1'b0, s};
    n = 1'b0;
    z = 1'b0;
    v = 1'b0;
    c = 1'b0;
    dm = 1'b0;
    sm = 1'b0;
    unique case (sz)
      `CCO_SZ_BYTE: begin
        n = diff[7];
        z = (diff[7:0] == 8'h00);
        c = (d[7:0] < s[7:0]);
        dm = d[7];
        sm = s[7];
      end
      `CCO_SZ_WORD: begin
        n = diff[15];
        z = (diff[15:0] == 16'h0000);
        c = (d[15:0] < s[15:0]);
        dm = d[15];
        sm = s[15];
      end
      default: begin
        n = diff[31];
        z = (diff[31:0] == 32'h0000_0000);
        c = diff[32];
        dm = d[31];
        sm = s[31];
      end
    endcase
    v = sub_overflow(dm, sm, n);
    sub_flags = {n, z, v, c};
  endfunction

  // ********************************
  // Address-mode and size checks
  // ********************************
  // Clear destination: data-alterable modes only
  function automatic logic ea_data_alterable(input logic [2:0] mode, input logic [2:0] rn);
    logic ok;
    ok = 1'b0;
    unique case (mode)
      `CCO_EA_DREG: ok = 1'b1;
      `CCO_EA_AREG: ok = 1'b0;
      `CCO_EA_IND: ok = 1'b1;
      `CCO_EA_POSTINC: ok = 1'b1;
      `CCO_EA_PREDEC: ok = 1'b1;
      `CCO_EA_DISP: ok = 1'b1;
      `CCO_EA_INDEX: ok = 1'b1;
      `CCO_EA_EXT: ok = (rn == `CCO_EXT_ABS_W) || (rn == `CCO_EXT_ABS_L);
    endcase
    ea_data_alterable = ok;
  endfunction

  // Compare source: every mode, register codes above immediate unused
  function automatic logic ea_any_source(input logic [2:0] mode, input logic [2:0] rn);
    logic ok;
    ok = 1'b0;
    unique case (mode)
      `CCO_EA_DREG: ok = 1'b1;
      `CCO_EA_AREG: ok = 1'b1;
      `CCO_EA_IND: ok = 1'b1;
      `CCO_EA_POSTINC: ok = 1'b1;
      `CCO_EA_PREDEC: ok = 1'b1;
      `CCO_EA_DISP: ok = 1'b1;
      `CCO_EA_INDEX: ok = 1'b1;
      `CCO_EA_EXT: ok = (rn <= `CCO_EXT_IMM);
    endcase
    ea_any_source = ok;
  endfunction

  // Clear size field: 11 names no size
  function automatic logic clr_size_ok(input logic [1:0] sz);
    logic ok;
    ok = 1'b0;
    unique case (sz)
      `CCO_SZ_BYTE: ok = 1'b1;
      `CCO_SZ_WORD: ok = 1'b1;
      `CCO_SZ_LONG: ok = 1'b1;
      2'h3: ok = 1'b0;
    endcase
    clr_size_ok = ok;
  endfunction

  // Operation size named by a compare opmode
  function automatic logic [1:0] opmode_size(input logic [2:0] opm);
    logic [1:0] sz;
    sz = `CCO_SZ_LONG;
    unique case (opm)
      `CCO_OPM_CMP_B: sz = `CCO_SZ_BYTE;
      `CCO_OPM_CMP_W: sz = `CCO_SZ_WORD;
      `CCO_OPM_CMP_L: sz = `CCO_SZ_LONG;
      `CCO_OPM_COMPARE_ADDRESS_REG_OP_W: sz = `CCO_SZ_WORD;
      `CCO_OPM_COMPARE_ADDRESS_REG_OP_L: sz = `CCO_SZ_LONG;
      default: sz = `CCO_SZ_LONG;
    endcase
    opmode_size = sz;
  endfunction

  // Word widened to a long by copying bit 15
  function automatic logic [31:0] sext_word(input logic [31:0] s);
    sext_word = {{16{s[15]}}, s[15:0]};
  endfunction

  // ********************************
  // Decode
  // ********************************
  wire logic [2:0] ea_mode = opcode[5:3];
  wire logic [2:0] ea_reg = opcode[2:0];
  wire logic [2:0] opmode = opcode[8:6];
  wire logic is_clr = (opcode[15:8] == `CCO_CLR_PREFIX); // RULE12
  wire logic is_cmpgrp = (opcode[15:12] == `CCO_CMP_PREFIX); // RULE13
  wire logic is_cmp = is_cmpgrp && (opmode == `CCO_OPM_CMP_B || opmode == `CCO_OPM_CMP_W
                                    || opmode == `CCO_OPM_CMP_L); // RULE6
  wire logic is_compare_address_reg_op = is_cmpgrp && (opmode == `CCO_OPM_COMPARE_ADDRESS_REG_OP_W || opmode == `CCO_OPM_COMPARE_ADDRESS_REG_OP_L); // RULE10
  wire logic [1:0] clr_size = opcode[7:6]; // RULE2
  wire logic [1:0] cmp_size = opmode_size(opmode); // RULE6
  // Clear: no address direct, only absolute forms under mode 111, size 11 illegal
  wire logic clr_ok = clr_size_ok(clr_size) && ea_data_alterable(ea_mode, ea_reg); // RULE2 RULE3
  // Data compare: all modes, address direct not at byte
  wire logic cmp_ok = ea_any_source(ea_mode, ea_reg)
                      && !(ea_mode == `CCO_EA_AREG && cmp_size == `CCO_SZ_BYTE); // RULE7
  wire logic compare_address_reg_op_ok = ea_any_source(ea_mode, ea_reg); // RULE11
  wire logic legal = (is_clr && clr_ok) || (is_cmp && cmp_ok) || (is_compare_address_reg_op && compare_address_reg_op_ok);
  // Word source sign-extended for the address compare
  wire logic [31:0] compare_address_reg_op_src = (opmode_size(opmode) == `CCO_SZ_WORD) ?
                               sext_word(src_operand[31:0]) : src_operand[31:0]; // RULE8
  wire logic [3:0] cmp_nzvc = sub_flags(data_register[31:0], src_operand[31:0], cmp_size); // RULE4 RULE5
  wire logic [3:0] compare_address_reg_op_nzvc = sub_flags(address_register[31:0], compare_address_reg_op_src, `CCO_SZ_LONG); // RULE8 RULE9
  wire logic [3:0] next_nzvc = is_clr ? 4'h4 : (is_cmp ? cmp_nzvc : compare_address_reg_op_nzvc); // RULE1
  wire logic [2:0] next_reg_sel = is_clr ? ea_reg : opcode[11:9];

  // ********************************
  // Sequencing
  // ********************************
  cco_state_e state;
  cco_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      CCO_IDLE: if (start) begin
        next_state = CCO_BUSY;
      end
      CCO_BUSY: next_state = CCO_DONE;
      CCO_DONE: next_state = CCO_IDLE;
      default: next_state = CCO_IDLE;
    endcase
  end

  wire logic take = (state == CCO_IDLE) && start;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CCO_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ********************************
  // Result registers
  // ********************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      illegal <= 1'b0;
    end else if (take) begin
      illegal <= !legal;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_sel <= 3'h0;
    end else if (take) begin
      reg_sel <= next_reg_sel;
    end
  end

  // Destination strobe and enables, clear only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_write <= 1'b0;
    end else if (take) begin
      dst_write <= legal && is_clr; // RULE1 RULE4 RULE8
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_data <= '0;
    end else if (take) begin
      dst_data <= '0; // RULE1
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_byte_en <= 4'h0;
    end else if (take) begin
      dst_byte_en <= is_clr ? size_mask(clr_size) : 4'h0; // RULE2
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_ea <= 6'h00;
    end else if (take) begin
      dst_ea <= opcode[5:0];
    end
  end

  // Flags, with X passed through
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_out <= '0;
    end else if (take) begin
      ccr_out <= {ccr_in[`CCO_CC_X], next_nzvc}; // RULE5 RULE9
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ccr_write <= 1'b0;
    end else if (take) begin
      ccr_write <= legal;
    end
  end

  assign done = (state == CCO_DONE);
endmodule

//--- cco_chk.sv
/* Port assertions for cco_decoder.
   Assumes starts at least 3 cycles apart; bound to every instance at the foot. */
`timescale 1ns/100ps
module cco_chk (
  input logic mclk,
  input logic sys_rst,
  input logic start,
  input logic [15:0] opcode,
  input cco_pkg::cco_ccr_t ccr_in,
  input logic done,
  input logic illegal,
  input logic [2:0] reg_sel,
  input logic dst_write,
  input logic [3:0] dst_byte_en,
  input cco_pkg::cco_ccr_t ccr_out,
  input logic ccr_write
);
  // ****
  // Properties
  // ****
  wire clr = start && opcode[15:8] == 8'h42;
  wire cmp = start && opcode[15:12] == 4'hb;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_DONE: assert property (start |-> !done ##1 !done ##1 done ##1 !done)
    else $error("done timing");
  AST_CLR_CC: assert property (clr |=> ccr_out[3:0] == 4'h4 && ccr_out[4] == $past(ccr_in[4]))
    else $error("clear flags");
  AST_CLR_SIZE: assert property (clr |=> illegal || dst_byte_en == {{2{$past(opcode[7])}}, |$past(opcode[7:6]), 1'b1})
    else $error("clear width");
  AST_CLR_MODE: assert property (clr && opcode[5:3] == 3'h1 |=> illegal && !dst_write && !ccr_write)
    else $error("clear mode");
  AST_CMP_REG: assert property (cmp |=> reg_sel == $past(opcode[11:9]) && !dst_write)
    else $error("compare register");
  AST_CMP_X: assert property (cmp |=> ccr_out[4] == $past(ccr_in[4]))
    else $error("compare extend");
  AST_CMPB_AREG: assert property (cmp && opcode[8:3] == 6'h01 |=> illegal && !ccr_write)
    else $error("byte address source");
  AST_COMPARE_ADDRESS_REG_OP_OK: assert property (cmp && opcode[7:6] == 2'h3 && opcode[5:3] != 3'h7 |=> !illegal && ccr_write)
    else $error("address compare mode");
endmodule
bind cco_decoder cco_chk u_chk (.*);

//--- clear_and_compare_ops_bench.sv
/* Self-checking bench for cco_decoder with an integer reference model.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/100ps
module clear_and_compare_ops_bench;
  import cco_pkg::*;
  logic mclk = 0;
  logic sys_rst = 1;
  logic start = 0;
  logic [15:0] opcode = 0;
  logic [31:0] src_operand = 0;
  logic [31:0] data_register = 0;
  logic [31:0] address_register = 0;
  logic [31:0] dst_data;
  cco_ccr_t ccr_in = 0;
  cco_ccr_t ccr_out;
  logic done, illegal, dst_write, ccr_write;
  logic [2:0] reg_sel;
  logic [3:0] dst_byte_en;
  logic [5:0] dst_ea;
  logic [31:0] e [4] = '{32'h0, 32'h7fffffff, 32'h80008000, 32'hffffff80};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  cco_decoder dut (.*);
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 4000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // One operation against the model
  // ****
  task automatic op(input logic [15:0] o, input logic [31:0] s, d, a, input cco_ccr_t c);
    logic [31:0] m, sx, dx, r;
    logic [32:0] df;
    logic il, ar, wr;
    int w;
    @(posedge mclk);
    start <= 1;
    opcode <= o;
    src_operand <= s;
    data_register <= d;
    address_register <= a;
    ccr_in <= c;
    @(posedge mclk);
    start <= 0;
    @(posedge mclk);
    #1;
    if (o[15:8] == 8'h42) begin
      il = o[7:6] == 2'h3 || o[5:3] == 3'h1 || (o[5:3] == 3'h7 && o[2:0] > 3'h1);
      wr = !il;
      chk(ccr_out, {c[4], 4'h4});
      chk(dst_byte_en, {{2{o[7]}}, |o[7:6], 1'b1});
      chk(reg_sel, o[2:0]);
    end else begin
      ar = o[7:6] == 2'h3;
      wr = 0;
      w = (o[7] || ar) ? 32 : o[6] ? 16 : 8;
      il = (o[8] && !ar) || (o[5:3] == 3'h7 && o[2:0] > 3'h4) || o[8:3] == 6'h01;
      m = w == 32 ? 32'hffffffff : (32'h1 << w) - 1;
      sx = (o[8:6] == 3'h3 ? {{16{s[15]}}, s[15:0]} : s) & m;
      dx = (ar ? a : d) & m;
      df = {1'b0, dx} - {1'b0, sx};
      r = df[31:0] & m;
      if (!(o[8] && !ar))
        chk(ccr_out, {c[4], r[w-1], r == 0, dx[w-1] != sx[w-1] && r[w-1] != dx[w-1], df[32]});
      chk(reg_sel, o[11:9]);
      chk(dst_byte_en, 4'h0);
    end
    chk({done, illegal, ccr_write, dst_write, dst_ea}, {1'b1, il, !il, wr, o[5:0]});
    chk(dst_data, 32'h0);
  endtask
  initial begin
    void'($urandom(64390));
    repeat (2) @(posedge mclk);
    sys_rst <= 0;
    for (int i = 0; i < 64; i++)
      op({8'h42, i[4:3], i[2:0], 3'($urandom)}, $urandom, $urandom, $urandom, 5'($urandom));
    $display("test clear done");
    for (int i = 0; i < 400; i++)
      op({4'hb, 12'($urandom)}, i % 2 ? $urandom : e[$urandom % 4], e[$urandom % 4], e[$urandom % 4],
        5'($urandom));
    $display("test compare done");
    report_and_stop();
  end
endmodule
